// >>> shared/scc_pkg.sv
package scc_pkg;

	// clock and time figures
	localparam int CLK_PERIOD_NS = 100;
	localparam int DEGLITCH_NS   = 10000;
	localparam int BLANK_NS      = 1000;
	localparam int LONG_DRIVE_NS = 20000;
	localparam int OFF_TIME_SELECT_LOW_NS   = 7000;
	localparam int OFF_TIME_SELECT_HIGH_NS  = 16000;
	localparam int OFF_TIME_SELECT_OPEN_NS  = 24000;
	localparam int OFF_TIME_SELECT_RES_NS   = 32000;

	// least times, rounded up to whole cycles
	localparam int CNT_W = 10;
	localparam logic [CNT_W-1:0] DEGLITCH_CYC =
		CNT_W'((DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] BLANK_CYC =
		CNT_W'((BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] LONG_DRIVE_CYC =
		CNT_W'((LONG_DRIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] OFF_TIME_SELECT_LOW_CYC =
		CNT_W'((OFF_TIME_SELECT_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] OFF_TIME_SELECT_HIGH_CYC =
		CNT_W'((OFF_TIME_SELECT_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] OFF_TIME_SELECT_OPEN_CYC =
		CNT_W'((OFF_TIME_SELECT_OPEN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] OFF_TIME_SELECT_RES_CYC =
		CNT_W'((OFF_TIME_SELECT_RES_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// fast-decay shares in percent of the off period
	localparam logic [6:0] PCT_NONE  = 7'h00;
	localparam logic [6:0] PCT_MIX30 = 7'h1e;
	localparam logic [6:0] PCT_MIX60 = 7'h3c;
	localparam logic [6:0] PCT_FULL  = 7'h64;
	localparam logic [6:0] PCT_STEP  = 7'h0a;
	localparam logic [6:0] SHARE_RST = 7'h1e;

	// comparator codes of the multi-level pins
	localparam logic [1:0] TRI_LOW  = 2'h0;
	localparam logic [1:0] TRI_OPEN = 2'h1;
	localparam logic [2:0] QUAD_LOW = 3'h0;
	localparam logic [2:0] QUAD_RES = 3'h1;
	localparam logic [2:0] QUAD_OPEN = 3'h3;
	localparam logic [3:0] DECAY_CODE_RST = 4'h0;
	localparam logic [2:0] OFF_TIME_SELECT_CODE_RST  = 3'h0;

	// gate patterns {hs_p, ls_p, hs_n, ls_n}
	localparam logic [3:0] GATE_OFF  = 4'h0;
	localparam logic [3:0] GATE_POS  = 4'h9;
	localparam logic [3:0] GATE_NEG  = 4'h6;
	localparam logic [3:0] GATE_SLOW = 4'h5;

	typedef enum logic [1:0] {LVL_LOW, LVL_HIGH, LVL_OPEN, LVL_RES}
		scc_level_e;
	typedef enum logic [2:0] {SCH_DYN, SCH_RIPPLE, SCH_MIX30,
		SCH_SLOWMIX, SCH_MIX60, SCH_SLOW} scc_scheme_e;
	typedef enum logic [1:0] {RIP_1PCT, RIP_2PCT, RIP_4PCT, RIP_6PCT}
		scc_ripple_e;
	typedef enum logic [1:0] {BS_IDLE, BS_DRIVE, BS_FAST, BS_SLOW}
		scc_bstate_e;

endpackage

// >>> shared/scc_tune_if.sv
`timescale 1ns/100ps
interface scc_tune_if;
	logic       cycle_done;
	logic       overshoot;
	logic       long_drive;
	logic [6:0] share;

	modport chopper (output cycle_done, overshoot, long_drive,
		input share);
	modport tuner (input cycle_done, overshoot, long_drive,
		output share);
endinterface

// >>> design/scc_deglitch.sv
`timescale 1ns/100ps
module scc_deglitch #(
	parameter int           W   = 4,
	parameter logic [W-1:0] RST = '0
) (
	// clock and reset
	input  wire logic         i_clock,
	input  wire logic         i_rst_b,
	// raw pin code and settled code
	input  wire logic [W-1:0] i_raw,
	output logic      [W-1:0] o_applied
);
	import scc_pkg::*;

	typedef struct packed {
		logic [W-1:0]     s1;
		logic [W-1:0]     s2;
		logic [W-1:0]     s3;
		logic [W-1:0]     cand;
		logic [CNT_W-1:0] cnt;
		logic [W-1:0]     applied;
	} scc_dg_s;

	scc_dg_s r_reg;
	scc_dg_s r_next;

	// a change restarts the count, so chatter never reaches the core
	always_comb begin
		r_next = r_reg;
		r_next.s1 = i_raw;
		r_next.s2 = r_reg.s1;
		r_next.s3 = r_reg.s2;
		if (r_reg.s2 == r_reg.s3 && r_reg.s3 != r_reg.cand) begin
			r_next.cand = r_reg.s3;
			r_next.cnt  = '0;
		end else if (r_reg.cand != r_reg.applied) begin
			r_next.cnt = r_reg.cnt + 1'b1;
			if (r_reg.cnt == DEGLITCH_CYC - 1'b1) begin
				r_next.applied = r_reg.cand;
			end
		end else begin
			r_next.cnt = '0;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			r_reg <= '{s1: RST, s2: RST, s3: RST, cand: RST,
				cnt: '0, applied: RST};
		end else begin
			r_reg <= r_next;
		end
	end

	assign o_applied = r_reg.applied;

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_b);

	AST_DEGLITCH_HOLD: assert property (
		r_reg.applied != $past(r_reg.applied)
		|-> $past(r_reg.cnt) == DEGLITCH_CYC - 1'b1
		&& $past(r_reg.cand) == r_reg.applied)
		else $error("setting applied before de-glitch interval");
endmodule

// >>> design/scc_fast_share_tuner.sv
`timescale 1ns/100ps
module scc_fast_share_tuner (
	// clock and reset
	input  wire logic i_clock,
	input  wire logic i_rst_b,
	// per-cycle report and share
	scc_tune_if.tuner tune
);
	import scc_pkg::*;

	typedef struct packed {
		logic [6:0] share;
	} scc_tn_s;

	scc_tn_s r_reg;
	scc_tn_s r_next;

	// overshoot wins over a long drive: losing regulation costs more
	always_comb begin
		r_next = r_reg;
		if (tune.cycle_done) begin
			if (tune.overshoot) begin
				r_next.share = (r_reg.share >= PCT_FULL - PCT_STEP)
					? PCT_FULL : r_reg.share + PCT_STEP;
			end else if (tune.long_drive) begin
				r_next.share = (r_reg.share <= PCT_STEP)
					? PCT_NONE : r_reg.share - PCT_STEP;
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			r_reg <= '{share: SHARE_RST};
		end else begin
			r_reg <= r_next;
		end
	end

	assign tune.share = r_reg.share;

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_b);

	AST_SHARE_UP: assert property (
		tune.cycle_done && tune.overshoot && tune.share < PCT_FULL
		|=> tune.share > $past(tune.share))
		else $error("share did not rise after overshoot");
	AST_SHARE_DOWN: assert property (
		tune.cycle_done && !tune.overshoot && tune.long_drive
		&& tune.share > PCT_NONE
		|=> tune.share < $past(tune.share))
		else $error("share did not fall after long drive");
	COV_SHARE_MAX: cover property (tune.share == PCT_FULL);
endmodule

// >>> design/scc_chopper.sv
`timescale 1ns/100ps
// Operation
// - On trip after drive, decay for the off period, then drive again.
// - Fast decay reverses bridge polarity against the driven current.
// - Slow decay turns on both low-side switches together.
// - Two decay selects map to six schemes per the select table.
// - Upper decay select open forces adaptive dynamic decay.
// - New decay scheme applies after ten microseconds of stable select.
// - Slow-mixed uses slow on rising steps, mixed on falling steps.
// - Full-step and non-circular half-step use the falling-step scheme in slow-mixed, not in adaptive mode; the code keys this on i_full_step_mode only.
// - Mixed decay starts fast for a share, then slow for the rest.
// - Adaptive mode picks slow, mixed or fast and tunes the fast share.
// - Share updates each cycle without a pending falling step: overshoot raises it, long drive lowers it.
// - Adaptive mode uses fast decay on falling steps.
// - Ripple mode holds slow decay until the valley level, no fixed off.
// - Off-time select sets ripple share 1, 2, 4 or 6 percent.
// - Off-time select sets off period 7, 16, 24 or 32 microseconds.
// - New off period applies after a ten microsecond de-glitch.
// - Comparator ignored for about one microsecond after drive starts.
// - Blanking interval is the minimum drive time.
// - Each decay select decodes as low, high or open.
// - Off-time select decodes as low, high, open or resistor.
module scc_chopper (
	// clock and reset
	input  wire logic                i_clock,
	input  wire logic                i_rst_b,
	// multi-level pin comparators, thermometer coded
	input  wire logic [1:0]          i_decay_select_low,
	input  wire logic [1:0]          i_decay_select_high,
	input  wire logic [2:0]          i_off_time_select,
	// microstep command from the indexer
	input  wire logic                i_enable,
	input  wire logic                i_step_strobe,
	input  wire logic                i_full_step_mode,
	input  wire logic [1:0][7:0]     i_mag,
	input  wire logic [1:0]          i_polarity,
	// winding current comparators
	input  wire logic [1:0]          i_at_trip_current_level,
	input  wire logic [1:0]          i_at_valley_current_level,
	// bridge gates and status
	output logic      [1:0][3:0]     o_bridge_gate,
	output scc_pkg::scc_scheme_e     o_decay_scheme,
	output scc_pkg::scc_ripple_e     o_ripple_sel
);
	import scc_pkg::*;

	typedef struct packed {
		scc_bstate_e      st;
		logic [CNT_W-1:0] cnt;
		logic [CNT_W-1:0] fast_cyc;
		logic [CNT_W-1:0] off_time_select_lat;
		logic             valley_mode;
		logic             pol;
		logic [7:0]       prev_mag;
		logic             incr;
		logic             fall_pend;
		logic             done;
		logic             over;
		logic             long_drv;
		logic [3:0]       gate;
	} scc_br_s;

	typedef struct packed {
		logic [3:0]       s1;
		logic [3:0]       s2;
		logic [3:0]       s3;
		logic [3:0]       filt;
		scc_br_s [1:0]    br;
		scc_scheme_e      scheme;
		logic [CNT_W-1:0] off_time_select_cyc;
		scc_ripple_e      ripple;
	} scc_chop_s;

	scc_chop_s r_reg;
	scc_chop_s r_next;

	logic [3:0]      decay_code;
	logic [2:0]      off_time_select_code;
	logic [1:0][6:0] share_w;

	// both settings de-glitched on their own timers
	scc_deglitch #(.W(4), .RST(DECAY_CODE_RST)) u_decay_dg (
		.i_clock   (i_clock),
		.i_rst_b   (i_rst_b),
		.i_raw     ({i_decay_select_high, i_decay_select_low}),
		.o_applied (decay_code)
	);

	scc_deglitch #(.W(3), .RST(OFF_TIME_SELECT_CODE_RST)) u_off_time_select_dg (
		.i_clock   (i_clock),
		.i_rst_b   (i_rst_b),
		.i_raw     (i_off_time_select),
		.o_applied (off_time_select_code)
	);

	// one share tuner per bridge
	scc_tune_if tune [2] ();

	for (genvar b = 0; b < 2; b++) begin : g_tune
		assign tune[b].cycle_done = r_reg.br[b].done;
		assign tune[b].overshoot  = r_reg.br[b].over;
		assign tune[b].long_drive = r_reg.br[b].long_drv;
		assign share_w[b]         = tune[b].share;
		scc_fast_share_tuner u_tuner (
			.i_clock (i_clock),
			.i_rst_b (i_rst_b),
			.tune    (tune[b])
		);
	end

	// three-level pin: mid band is the floating pin
	function automatic scc_level_e tri_level(input logic [1:0] c);
		if (c == TRI_LOW) begin
			return LVL_LOW;
		end else if (c == TRI_OPEN) begin
			return LVL_OPEN;
		end
		return LVL_HIGH;
	endfunction

	// four-level pin; odd code 2 reads resistor, any code with bit 2 set reads high
	function automatic scc_level_e quad_level(input logic [2:0] c);
		if (c == QUAD_LOW) begin
			return LVL_LOW;
		end else if (c == QUAD_RES) begin
			return LVL_RES;
		end else if (c == QUAD_OPEN) begin
			return LVL_OPEN;
		end else if (c[2]) begin
			return LVL_HIGH;
		end
		return LVL_RES;
	endfunction

	scc_level_e  lvl_lo;
	scc_level_e  lvl_hi;
	scc_level_e  lvl_t;
	scc_br_s     br;
	logic        incr_eff;
	logic        fall_set;
	logic [6:0]  pct;
	logic [16:0] prod;
	logic [CNT_W-1:0] cnt1;

	always_comb begin
		lvl_lo   = tri_level(decay_code[1:0]);
		lvl_hi   = tri_level(decay_code[3:2]);
		lvl_t    = quad_level(off_time_select_code);
		br       = '0;
		incr_eff = 1'b0;
		fall_set = 1'b0;
		pct      = PCT_NONE;
		prod     = '0;
		cnt1     = '0;
		r_next   = r_reg;

		// comparators: a change counts once stages two and three agree
		r_next.s1 = {i_at_valley_current_level, i_at_trip_current_level};
		r_next.s2 = r_reg.s1;
		r_next.s3 = r_reg.s2;
		if (r_reg.s2 == r_reg.s3) begin
			r_next.filt = r_reg.s3;
		end

		// scheme from the settled select levels
		if (lvl_hi == LVL_OPEN) begin
			r_next.scheme = SCH_DYN;
		end else begin
			case (lvl_lo)
				LVL_LOW: begin
					r_next.scheme = (lvl_hi == LVL_HIGH)
						? SCH_RIPPLE : SCH_DYN;
				end
				LVL_HIGH: begin
					r_next.scheme = (lvl_hi == LVL_HIGH)
						? SCH_SLOWMIX : SCH_MIX30;
				end
				default: begin
					r_next.scheme = (lvl_hi == LVL_HIGH)
						? SCH_SLOW : SCH_MIX60;
				end
			endcase
		end

		// off period and ripple share from one pin
		case (lvl_t)
			LVL_LOW: begin
				r_next.off_time_select_cyc = OFF_TIME_SELECT_LOW_CYC;
				r_next.ripple   = RIP_1PCT;
			end
			LVL_HIGH: begin
				r_next.off_time_select_cyc = OFF_TIME_SELECT_HIGH_CYC;
				r_next.ripple   = RIP_2PCT;
			end
			LVL_OPEN: begin
				r_next.off_time_select_cyc = OFF_TIME_SELECT_OPEN_CYC;
				r_next.ripple   = RIP_4PCT;
			end
			default: begin
				r_next.off_time_select_cyc = OFF_TIME_SELECT_RES_CYC;
				r_next.ripple   = RIP_6PCT;
			end
		endcase

		for (int b = 0; b < 2; b++) begin
			br = r_reg.br[b];
			br.done = 1'b0;
			fall_set = 1'b0;

			// step direction from magnitude change
			if (i_step_strobe) begin
				br.prev_mag = i_mag[b];
				br.incr = i_mag[b] > r_reg.br[b].prev_mag;
				fall_set = i_mag[b] < r_reg.br[b].prev_mag;
			end
			incr_eff = br.incr & ~i_full_step_mode;
			cnt1 = r_reg.br[b].cnt + 1'b1;

			case (r_reg.br[b].st)
				BS_IDLE: begin
					if (i_enable) begin
						br.st  = BS_DRIVE;
						br.cnt = '0;
						br.pol = i_polarity[b];
					end
				end
				BS_DRIVE: begin
					if (r_reg.br[b].cnt != '1) begin
						br.cnt = cnt1;
					end
					// trip ignored until blanking ends
					if (r_reg.br[b].cnt >= BLANK_CYC
						&& r_reg.filt[b]) begin
						br.valley_mode = 1'b0;
						case (r_reg.scheme)
							SCH_SLOW: pct = PCT_NONE;
							SCH_MIX30: pct = PCT_MIX30;
							SCH_MIX60: pct = PCT_MIX60;
							SCH_SLOWMIX: begin
								pct = incr_eff ? PCT_NONE : PCT_MIX30;
							end
							SCH_RIPPLE: begin
								br.valley_mode = 1'b1;
							end
							default: begin
								if (r_reg.br[b].fall_pend) begin
									pct = PCT_FULL;
									br.fall_pend = 1'b0;
								end else begin
									pct = share_w[b];
									br.done = 1'b1;
								end
							end
						endcase
						br.over = r_reg.br[b].cnt == BLANK_CYC;
						br.long_drv = r_reg.br[b].cnt >= LONG_DRIVE_CYC;
						// fast part as a fraction of the off count
						prod = 17'(r_reg.off_time_select_cyc) * 17'(pct);
						br.fast_cyc = CNT_W'(prod / 17'h0_0064);
						br.off_time_select_lat = r_reg.off_time_select_cyc;
						br.cnt = '0;
						br.st = (!br.valley_mode && br.fast_cyc != '0)
							? BS_FAST : BS_SLOW;
					end
				end
				BS_FAST, BS_SLOW: begin
					br.cnt = cnt1;
					if (r_reg.br[b].valley_mode) begin
						if (r_reg.filt[2+b]) begin
							br.st  = BS_DRIVE;
							br.cnt = '0;
							br.pol = i_polarity[b];
						end
					end else if (cnt1 >= r_reg.br[b].off_time_select_lat) begin
						br.st  = BS_DRIVE;
						br.cnt = '0;
						br.pol = i_polarity[b];
					end else if (cnt1 >= r_reg.br[b].fast_cyc) begin
						br.st = BS_SLOW;
					end
				end
				default: br.st = BS_IDLE;
			endcase

			if (!i_enable) begin
				br.st = BS_IDLE;
			end
			// a falling step in the clearing cycle is kept
			if (fall_set) begin
				br.fall_pend = 1'b1;
			end

			// gates follow the next state so they line up with it
			case (br.st)
				BS_DRIVE: br.gate = br.pol ? GATE_POS : GATE_NEG;
				BS_FAST: br.gate = br.pol ? GATE_NEG : GATE_POS;
				BS_SLOW: br.gate = GATE_SLOW;
				default: br.gate = GATE_OFF;
			endcase
			r_next.br[b] = br;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			r_reg <= '{s1: '0, s2: '0, s3: '0, filt: '0,
				br: '0, scheme: SCH_DYN, off_time_select_cyc: OFF_TIME_SELECT_LOW_CYC,
				ripple: RIP_1PCT};
		end else begin
			r_reg <= r_next;
		end
	end

	// outputs straight from the state register
	always_comb begin
		for (int b = 0; b < 2; b++) begin
			o_bridge_gate[b] = r_reg.br[b].gate;
		end
	end
	assign o_decay_scheme = r_reg.scheme;
	assign o_ripple_sel   = r_reg.ripple;

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_b);

	AST_TRIP_ENDS_DRIVE: assert property (
		r_reg.br[0].st == BS_DRIVE && r_reg.br[0].cnt >= BLANK_CYC
		&& r_reg.filt[0] && i_enable
		|=> r_reg.br[0].st inside {BS_FAST, BS_SLOW})
		else $error("trip did not start decay");
	AST_FAST_REVERSE: assert property (
		r_reg.br[0].st == BS_FAST
		|-> r_reg.br[0].gate == (r_reg.br[0].pol ? GATE_NEG : GATE_POS))
		else $error("fast decay not reversed");
	AST_SLOW_LOWSIDE: assert property (
		r_reg.br[0].st == BS_SLOW |-> r_reg.br[0].gate == GATE_SLOW)
		else $error("slow decay not on low sides");
	AST_UPPER_OPEN: assert property (
		decay_code[3:2] == TRI_OPEN ##1 decay_code[3:2] == TRI_OPEN
		|-> r_reg.scheme == SCH_DYN)
		else $error("open upper select not dynamic");
	AST_BLANK_MIN: assert property (
		r_reg.br[0].st == BS_DRIVE && i_enable
		##1 r_reg.br[0].st inside {BS_FAST, BS_SLOW}
		|-> $past(r_reg.br[0].cnt) >= BLANK_CYC)
		else $error("drive ended inside blanking");
	AST_OFF_LEN: assert property (
		$past(r_reg.br[0].st) inside {BS_FAST, BS_SLOW}
		&& !$past(r_reg.br[0].valley_mode) && $past(i_enable)
		&& r_reg.br[0].st == BS_DRIVE
		|-> $past(r_reg.br[0].cnt) + 1'b1 == $past(r_reg.br[0].off_time_select_lat))
		else $error("off period length wrong");
	AST_SLOWMIX_RISE: assert property (
		r_reg.scheme == SCH_SLOWMIX && r_reg.br[0].incr
		&& !i_full_step_mode && !i_step_strobe
		&& r_reg.br[0].st == BS_DRIVE && r_reg.br[0].cnt >= BLANK_CYC
		&& r_reg.filt[0] && i_enable
		|=> r_reg.br[0].st == BS_SLOW)
		else $error("rising step in slow-mixed not slow");
	AST_FALL_FAST: assert property (
		r_reg.scheme == SCH_DYN && r_reg.br[0].fall_pend
		&& r_reg.br[0].st == BS_DRIVE && r_reg.br[0].cnt >= BLANK_CYC
		&& r_reg.filt[0] && i_enable
		|=> r_reg.br[0].fast_cyc == r_reg.br[0].off_time_select_lat)
		else $error("falling step not full fast");

	COV_MIXED: cover property (r_reg.br[0].st == BS_FAST
		##1 r_reg.br[0].st == BS_SLOW);
	COV_RIPPLE: cover property (r_reg.br[0].valley_mode
		&& r_reg.br[0].st == BS_SLOW ##1 r_reg.br[0].st == BS_DRIVE);
	COV_DYN_DONE: cover property (r_reg.br[0].done);
endmodule

// >>> verif/scc_winding_model.sv
`timescale 1ns/100ps
// winding stand-in: signed current, comparators on its magnitude
module scc_winding_model #(
	parameter int TRIP   = 4000,
	parameter int VALLEY = 3760
) (
	// clock and bridge gates
	input  wire logic        i_clock,
	input  wire logic [3:0]  i_gate,
	input  wire logic [15:0] i_rise,
	// current comparators
	output logic             o_trip,
	output logic             o_valley
);
	int cur = 0;
	int mag;

	// drive pushes at i_rise, opposing drive sheds fast, slow bleeds
	always @(posedge i_clock) begin
		case (i_gate)
			4'h9: cur = (cur >= 0) ? cur + int'(i_rise) : cur + 64;
			4'h6: cur = (cur <= 0) ? cur - int'(i_rise) : cur - 64;
			4'h5: cur = (cur > 8) ? cur - 8 : ((cur < -8) ? cur + 8 : 0);
			default: cur = (cur > 64) ? cur - 64 : ((cur < -64) ? cur + 64 : 0);
		endcase
		// cap keeps a stuck bridge from running away
		if (cur > 2 * TRIP) cur = 2 * TRIP;
		if (cur < -2 * TRIP) cur = -2 * TRIP;
		mag = (cur < 0) ? -cur : cur;
		o_trip <= (mag >= TRIP);
		o_valley <= (mag <= VALLEY);
	end
endmodule

// >>> verif/test_scc_chopper.sv
`timescale 1ns/100ps
module test_scc_chopper;
	import scc_pkg::*;
	logic            i_clock, i_rst_b, i_enable, i_step_strobe;
	logic            i_full_step_mode;
	logic [1:0]      i_decay_select_low, i_decay_select_high;
	logic [1:0]      i_polarity;
	wire [1:0]       trip, valley;
	logic [2:0]      i_off_time_select;
	logic [1:0][7:0] i_mag;
	logic [1:0][3:0] gate;
	logic [15:0]     rise;
	scc_scheme_e     scheme;
	scc_ripple_e     rip;
	int              mismatches = 0, check_count = 0, cycles = 0;
	int              nd, nf, ns, prev, k;
	int              toffs[4] = '{70, 160, 240, 320};
	logic [2:0]      tcode[4] = '{3'h0, 3'h7, 3'h3, 3'h1};
	logic [1:0]      lvl[3] = '{2'h0, 2'h1, 2'h3};

	scc_chopper i_scc_chopper (
		.i_clock(i_clock), .i_rst_b(i_rst_b),
		.i_decay_select_low(i_decay_select_low),
		.i_decay_select_high(i_decay_select_high),
		.i_off_time_select(i_off_time_select), .i_enable(i_enable),
		.i_step_strobe(i_step_strobe), .i_full_step_mode(i_full_step_mode),
		.i_mag(i_mag), .i_polarity(i_polarity),
		.i_at_trip_current_level(trip), .i_at_valley_current_level(valley),
		.o_bridge_gate(gate), .o_decay_scheme(scheme), .o_ripple_sel(rip));

	// one winding per bridge
	for (genvar b = 0; b < 2; b++) begin : g_wind
		scc_winding_model i_scc_winding_model (.i_clock(i_clock),
			.i_gate(gate[b]), .i_rise(rise), .o_trip(trip[b]),
			.o_valley(valley[b]));
	end

	// 10 MHz clock
	initial begin
		i_clock = 1'b0;
		forever #50 i_clock = ~i_clock;
	end

	// hang guard, well above the longest expected run
	always @(posedge i_clock) begin
		cycles++;
		if (cycles == 90000) begin
			mismatches++;
			$display("[FAIL] %0t run timed out", $time);
			end_sim();
		end
	end

	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input logic ok, input string msg);
		check_count++;
		if (ok !== 1'b1) begin
			mismatches++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask

	// sample just after the edge so the design's updates have landed
	task automatic tick(input int n);
		repeat (n) @(posedge i_clock);
		#1;
	endtask

	task automatic pins(input logic [1:0] lo, hi, input logic [2:0] t);
		@(posedge i_clock);
		i_decay_select_low <= lo;
		i_decay_select_high <= hi;
		i_off_time_select <= t;
	endtask

	task automatic step(input logic [7:0] m, input logic fs);
		@(posedge i_clock);
		i_mag <= {m, m};
		i_full_step_mode <= fs;
		i_step_strobe <= 1'b1;
		@(posedge i_clock);
		i_step_strobe <= 1'b0;
	endtask

	// reference decode of the two decay pins
	function automatic scc_scheme_e exp_sch(input logic [1:0] lo, hi);
		if (hi == 2'h1) return SCH_DYN;
		case (lo)
			2'h0: return hi[0] ? SCH_RIPPLE : SCH_DYN;
			2'h1: return hi[0] ? SCH_SLOW : SCH_MIX60;
			default: return hi[0] ? SCH_SLOWMIX : SCH_MIX30;
		endcase
	endfunction

	// lengths of one fresh drive and the decay after it, bridge 0
	task automatic off_phase();
		logic [3:0] dp, fp;
		dp = i_polarity[0] ? GATE_POS : GATE_NEG;
		fp = i_polarity[0] ? GATE_NEG : GATE_POS;
		nd = 0;
		nf = 0;
		ns = 0;
		while (gate[0] === dp) tick(1);
		while (gate[0] !== dp) tick(1);
		while (gate[0] === dp) begin nd++; tick(1); end
		while (gate[0] === fp) begin nf++; tick(1); end
		while (gate[0] === GATE_SLOW) begin ns++; tick(1); end
	endtask

	task automatic chop(input int off_time_select, input int pct);
		off_phase();
		chk(nd >= int'(BLANK_CYC), "drive shorter than blanking");
		chk(nf + ns == off_time_select, "off period length");
		chk(nf == off_time_select * pct / 100, "fast share length");
	endtask

	initial begin
		i_rst_b = 1'b0;
		i_enable = 1'b0;
		i_step_strobe = 1'b0;
		i_full_step_mode = 1'b0;
		i_decay_select_low = 2'h0;
		i_decay_select_high = 2'h0;
		i_off_time_select = 3'h0;
		i_mag = '0;
		i_polarity = 2'h3;
		rise = 16'h03e8;
		void'($urandom(32'h13ce));
		repeat (10) @(posedge i_clock);
		i_rst_b <= 1'b1;
		tick(1);
		chk(scheme === SCH_DYN && rip === RIP_1PCT && gate === '0,
			"reset");
		// every level pair of the decay pins
		foreach (lvl[a]) foreach (lvl[b]) begin
			pins(lvl[a], lvl[b], 3'h0);
			tick(115);
			chk(scheme === exp_sch(lvl[a], lvl[b]), "decay decode");
		end
		// a glitch shorter than the de-glitch time is ignored
		pins(2'h0, 2'h0, 3'h0);
		tick(60);
		pins(2'h3, 2'h3, 3'h0);
		tick(115);
		chk(scheme === SCH_SLOWMIX, "glitch applied");
		pins(2'h0, 2'h0, 3'h0);
		tick(95);
		chk(scheme === SCH_SLOWMIX, "applied too early");
		tick(25);
		chk(scheme === SCH_DYN, "not applied");
		// off-time levels with 30 percent mixed, random polarity
		@(posedge i_clock);
		i_enable <= 1'b1;
		for (k = 0; k < 4; k++) begin
			@(posedge i_clock);
			i_polarity <= 2'($urandom);
			pins(2'h3, 2'h0, tcode[k]);
			tick(115);
			chk(rip === scc_ripple_e'(k), "ripple select");
			chop(toffs[k], 30);
		end
		pins(2'h1, 2'h0, 3'h0);
		tick(115);
		chop(70, 60);
		pins(2'h1, 2'h3, 3'h0);
		tick(115);
		chop(70, 0);
		// enable low idles the bridges
		@(posedge i_clock);
		i_enable <= 1'b0;
		tick(3);
		chk(gate === '0, "not idle when disabled");
		// ripple: slow until valley, about 30 cycles here
		pins(2'h0, 2'h3, 3'h0);
		rise <= 16'h0008;
		tick(115);
		@(posedge i_clock);
		i_enable <= 1'b1;
		off_phase();
		chk(nf == 0 && ns >= 30 && ns <= 45, "ripple off time");
		// slow-mixed: slow on rising, mixed on falling steps
		pins(2'h3, 2'h3, 3'h0);
		tick(115);
		step(8'h40, 1'b0);
		off_phase();
		chk(nf == 0, "rising step not slow");
		step(8'h20, 1'b0);
		off_phase();
		chk(nf == 21, "falling step not mixed");
		step(8'h60, 1'b1);
		off_phase();
		chk(nf == 21, "full step not mixed");
		step(8'h60, 1'b0);
		// adaptive: overshoot raises the share up to all fast
		pins(2'h0, 2'h0, 3'h0);
		rise <= 16'h03e8;
		tick(115);
		// spend any falling step left pending from slow-mixed
		off_phase();
		prev = 0;
		repeat (12) begin
			off_phase();
			chk(nf >= prev, "share fell on overshoot");
			prev = nf;
		end
		chk(nf == 70, "share not full");
		// long drives lower it down to slow only
		rise <= 16'h0004;
		repeat (14) begin
			off_phase();
			chk(nf <= prev, "share rose on long drive");
			prev = nf;
		end
		chk(nf == 0, "share not empty");
		// step inside slow decay, so the next measured trip takes it
		while (gate[0] !== GATE_SLOW) tick(1);
		step(8'h10, 1'b0);
		off_phase();
		chk(nf == 70, "falling step not fast");
		end_sim();
	end
endmodule
